// ---- logic/bmm_gpr_ram.sv ----
// 64 x 8 general purpose register storage
`timescale 1ns/1ps
module bmm_gpr_ram
  import bmm_pkg::*;
(
  // clock
  input  wire logic                 clk,
  // write port
  input  wire logic                 wr_en,
  input  wire logic [GPR_IDX_W-1:0] wr_idx,
  input  wire logic [DATA_W-1:0]    wr_data,
  // read port
  input  wire logic [GPR_IDX_W-1:0] rd_idx,
  output logic      [DATA_W-1:0]    rd_data
);
  // contents are not cleared by reset, like plain static ram
  logic [DATA_W-1:0] mem [GPR_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_comb begin
    rd_data = mem[rd_idx];
  end
endmodule

// ---- logic/bmm_map.sv ----
// banked memory address map: program counter and data decode
//
// Summary of operation
// - 13-bit program counter over 8K words
// - fetch address wraps onto lowest 1K
// - reset starts fetch at address zero
// - interrupt loads program counter with four
// - data space split into two banks
// - low 32 locations per bank are sfrs
// - 20h-5Fh ram, shared by both banks
// - unimplemented data locations read zero
// - status bit 5 picks the bank for direct access, pointer bit 7 for indirect
// - 64-byte ram, direct or via pointer
`timescale 1ns/1ps
module bmm_map
  import bmm_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // program counter control from the core
  input  wire logic                   pc_load,
  input  wire logic [PC_W-1:0]        pc_load_value,
  input  wire logic                   pc_advance,
  input  wire logic                   intr_take,
  // status register bits from the core
  input  wire logic [DATA_W-1:0]      status_value,
  // data access request
  input  wire logic                   data_req,
  input  wire logic                   data_we,
  input  wire logic                   data_indirect,
  input  wire logic [FILE_ADDR_W-1:0] file_field,
  input  wire logic [EFF_ADDR_W-1:0]  indirect_pointer,
  input  wire logic [DATA_W-1:0]      data_wdata,
  // sfr read data supplied by the core for the decoded slot
  input  wire logic [DATA_W-1:0]      sfr_rdata,
  // program side answer
  output logic      [PC_W-1:0]        pc,
  output logic      [PROG_IMPL_W-1:0] fetch_addr,
  // data side answer, one cycle after the request
  output logic                        data_valid,
  output logic      [DATA_W-1:0]      data_rdata,
  // sfr strobe to the core, one cycle after the request
  output logic                        sfr_sel,
  output logic      [SFR_IDX_W-1:0]   sfr_index,
  output logic                        sfr_bank,
  output logic                        sfr_we,
  output logic      [DATA_W-1:0]      sfr_wdata,
  // bank in force, for the core's own use
  output logic                        bank_select_bit
);
  // program side
  logic [PC_W-1:0]        next_pc;
  logic [PC_W-1:0]        pc_step;
  // data side
  logic [EFF_ADDR_W-1:0]  direct_addr;
  logic [EFF_ADDR_W-1:0]  eff_addr;
  bmm_region_e            region;
  logic                   sfr_hit;
  logic                   gpr_hit;
  logic                   access_we;
  logic                   gpr_we;
  logic [DATA_W-1:0]      gpr_rdata;
  logic [GPR_IDX_W-1:0]   gpr_idx;
  logic [DATA_W-1:0]      next_rdata;

  // 13-bit add, so 1FFF steps back round to zero
  always_comb begin
    pc_step = pc + 13'h0001;
  end

  // interrupt wins over a jump, a jump over a step
  always_comb begin
    if (intr_take) begin
      next_pc = INTR_VECTOR;
    end else if (pc_load) begin
      next_pc = pc_load_value;
    end else if (pc_advance) begin
      next_pc = pc_step;
    end else begin
      next_pc = pc;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pc <= RESET_VECTOR;
    end else begin
      pc <= next_pc;
    end
  end

  // upper bits dropped so any address folds onto the implemented 1K
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_addr <= RESET_VECTOR[PROG_IMPL_W-1:0];
    end else begin
      fetch_addr <= next_pc[PROG_IMPL_W-1:0];
    end
  end

  // direct access: bank bit on top of the 7-bit field
  always_comb begin
    direct_addr = {status_value[STATUS_BANK_BIT], file_field};
  end

  // upper bank and page bits are ignored; software must keep them zero
  always_comb begin
    if (data_indirect) begin
      eff_addr = indirect_pointer;
    end else begin
      eff_addr = direct_addr;
    end
  end

  // both banks decode the same 7-bit offset, so ram is mirrored
  always_comb begin
    region = bmm_decode(eff_addr[FILE_ADDR_W-1:0]);
  end

  // hits only count with a live request, so idle cycles strobe nothing
  always_comb begin
    sfr_hit   = data_req && (region == BMM_REGION_SFR);
    gpr_hit   = data_req && (region == BMM_REGION_GPR);
    access_we = data_req && data_we;
  end

  // offsets outside the ram alias an index but never write it
  always_comb begin
    gpr_idx = GPR_IDX_W'(eff_addr[FILE_ADDR_W-1:0] - GPR_LO);
    gpr_we  = access_we && gpr_hit;
  end

  // one index for both ports: a read in the write cycle sees the old byte
  bmm_gpr_ram u_gpr (
    .clk     (clk),
    .wr_en   (gpr_we),
    .wr_idx  (gpr_idx),
    .wr_data (data_wdata),
    .rd_idx  (gpr_idx),
    .rd_data (gpr_rdata)
  );

  always_comb begin
    unique case (region)
      BMM_REGION_SFR:  next_rdata = sfr_rdata;
      BMM_REGION_GPR:  next_rdata = gpr_rdata;
      BMM_REGION_NONE: next_rdata = ZERO_BYTE;
      default:         next_rdata = ZERO_BYTE;
    endcase
  end

  // answer pulse, one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      data_valid <= 1'b0;
    end else begin
      data_valid <= data_req;
    end
  end

  // idle cycles read zero, so a stale byte never leaks out
  always_ff @(posedge clk) begin
    if (rst) begin
      data_rdata <= ZERO_BYTE;
    end else begin
      data_rdata <= data_req ? next_rdata : ZERO_BYTE;
    end
  end

  // sfr strobe registered so every output leaves a flip-flop
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_sel <= 1'b0;
    end else begin
      sfr_sel <= sfr_hit;
    end
  end

  // write strobe only for a decoded sfr slot
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_we <= 1'b0;
    end else begin
      sfr_we <= access_we && sfr_hit;
    end
  end

  // slot, bank and data follow the address every cycle; sel and we qualify them
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_index <= '0;
    end else begin
      sfr_index <= eff_addr[SFR_IDX_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_bank <= 1'b0;
    end else begin
      sfr_bank <= eff_addr[FILE_ADDR_W];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_wdata <= ZERO_BYTE;
    end else begin
      sfr_wdata <= data_wdata;
    end
  end

  // registered copy of the live bank bit
  always_ff @(posedge clk) begin
    if (rst) begin
      bank_select_bit <= 1'b0;
    end else begin
      bank_select_bit <= status_value[STATUS_BANK_BIT];
    end
  end
endmodule

// ---- logic/bmm_pkg.sv ----
// constants for the banked memory address map
package bmm_pkg;
  localparam int PC_W           = 13;
  localparam int INSN_W         = 14;
  localparam int PROG_IMPL_W    = 10;
  localparam int FILE_ADDR_W    = 7;
  localparam int EFF_ADDR_W     = 8;
  localparam int DATA_W         = 8;
  localparam int GPR_DEPTH      = 64;
  localparam int GPR_IDX_W      = 6;
  localparam int SFR_COUNT      = 32;
  localparam int SFR_IDX_W      = 5;
  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] INTR_VECTOR  = 13'h0004;
  localparam logic [FILE_ADDR_W-1:0] GPR_LO = 7'h20;
  localparam logic [FILE_ADDR_W-1:0] GPR_HI = 7'h5F;
  localparam logic [FILE_ADDR_W-1:0] SFR_HI = 7'h1F;
  localparam int STATUS_BANK_BIT = 5;
  localparam int STATUS_UPPER_BANK_BIT = 6;
  localparam int STATUS_INDIRECT_PAGE_BIT = 7;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  typedef enum logic [1:0] {
    BMM_REGION_SFR  = 2'b00,
    BMM_REGION_GPR  = 2'b01,
    BMM_REGION_NONE = 2'b10
  } bmm_region_e;
  // shared decode of a 7-bit file offset into its region
  function automatic bmm_region_e bmm_decode(input logic [FILE_ADDR_W-1:0] a);
    if (a <= SFR_HI) begin
      return BMM_REGION_SFR;
    end else if (a >= GPR_LO && a <= GPR_HI) begin
      return BMM_REGION_GPR;
    end
    return BMM_REGION_NONE;
  endfunction
endpackage

// ---- verif/bmm_core_model.sv ----
// core-side model: status byte and sfr read data
`timescale 1ns/1ps
module bmm_core_model
  import bmm_pkg::*;
(
  // from bench
  input  wire logic                   bank,
  input  wire logic [FILE_ADDR_W-1:0] file_field,
  // to block
  output logic      [DATA_W-1:0]      status_value,
  output logic      [DATA_W-1:0]      sfr_rdata
);
  // reserved page bits always kept low
  assign status_value = {2'h0, bank, 5'h00};
  // slot-dependent pattern, so a wrong slot shows
  assign sfr_rdata = {3'h5, file_field[4:0]};
endmodule

// ---- verif/bmm_map_tb_top.sv ----
// self-checking bench for the banked memory address map
`timescale 1ns/1ps
module bmm_map_tb_top;
  import bmm_pkg::*;
  logic clk = 0, rst = 1, pc_load = 0, pc_advance = 0, intr_take = 0, bank = 0;
  logic data_req = 0, data_we = 0, data_indirect = 0;
  logic [PC_W-1:0] pc_load_value = '0, pc;
  logic [FILE_ADDR_W-1:0] file_field = '0;
  logic [DATA_W-1:0] indirect_pointer = '0, data_wdata = '0, status_value, sfr_rdata;
  logic [DATA_W-1:0] data_rdata, sfr_wdata;
  logic [PROG_IMPL_W-1:0] fetch_addr;
  logic [SFR_IDX_W-1:0] sfr_index;
  logic data_valid, sfr_sel, sfr_bank, sfr_we, bank_select_bit;
  int num_errors = 0, cmp_count = 0;
  bmm_core_model core (.bank, .file_field, .status_value, .sfr_rdata);
  bmm_map uut (.clk, .rst, .pc_load, .pc_load_value, .pc_advance, .intr_take, .status_value,
    .data_req, .data_we, .data_indirect, .file_field, .indirect_pointer, .data_wdata, .sfr_rdata,
    .pc, .fetch_addr, .data_valid, .data_rdata, .sfr_sel, .sfr_index, .sfr_bank, .sfr_we,
    .sfr_wdata, .bank_select_bit);
  always #50 clk = ~clk;
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // one access; answer is taken at the edge after the request
  task automatic acc(logic w, ind, b, logic [6:0] f, logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk) #1 {data_req, data_we, data_indirect, bank} = {1'b1, w, ind, b};
    {file_field, data_wdata, indirect_pointer} = {f, wd, b, f};
    @(posedge clk) #1 data_req = 0;
    chk("valid", data_valid, 1);
    rd = data_rdata;
  endtask
  task automatic t_pc;
    chk("pc reset", pc, 0);
    {pc_load, pc_advance, pc_load_value} = {2'h3, 13'h1FFF};
    @(posedge clk) #1 chk("pc load", pc, 16'h1FFF);
    pc_load = 0;
    @(posedge clk) #1 chk("pc wrap", pc, 0);
    {intr_take, pc_load, pc_load_value} = {2'h3, 13'h0ABC};
    @(posedge clk) #1 chk("intr", pc, 16'h0004);
    intr_take = 0;
    @(posedge clk) #1 chk("fetch", fetch_addr, 16'h02BC);
    {pc_load, pc_advance} = 0;
  endtask
  task automatic t_gpr;
    logic [7:0] r;
    acc(1, 0, 1, 7'h20, 8'hAB, r);
    acc(0, 0, 0, 7'h20, 0, r);
    chk("gpr bank", r, 16'h00AB);
    acc(1, 1, 0, 7'h5F, 8'h5A, r);
    acc(0, 0, 1, 7'h5F, 0, r);
    chk("gpr ptr", r, 16'h005A);
    acc(0, 1, 1, 7'h20, 0, r);
    chk("gpr ptr rd", r, 16'h00AB);
  endtask
  task automatic t_unimpl;
    logic [7:0] r;
    acc(1, 0, 1, 7'h60, 8'hFF, r);
    acc(0, 0, 1, 7'h60, 0, r);
    chk("unimpl", r, 0);
    acc(0, 0, 0, 7'h20, 0, r);
    chk("no alias", r, 16'h00AB);
  endtask
  task automatic t_sfr;
    logic [7:0] r;
    acc(0, 0, 1, 7'h05, 0, r);
    chk("sfr data", r, 16'h00A5);
    chk("sfr bank", {sfr_sel, sfr_bank, bank_select_bit}, 7);
    acc(1, 0, 0, 7'h1F, 8'h3C, r);
    chk("sfr wr", {sfr_we, sfr_wdata}, 16'h013C);
    @(posedge clk) #1 chk("idle", {data_valid, data_rdata, sfr_sel, sfr_we}, 0);
  endtask
  task automatic t_rerun;
    @(posedge clk) #1 rst = 1;
    @(posedge clk) #1 rst = 0;
    chk("pc rerun", pc, 0);
    chk("fetch rerun", fetch_addr, 0);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 0;
    t_pc();
    t_gpr();
    t_unimpl();
    t_sfr();
    t_rerun();
    tally_and_finish();
  end
endmodule

// ---- verif/bmm_sva.sv ----
// port assertions for the banked memory address map
`timescale 1ns/1ps
module bmm_sva
  import bmm_pkg::*;
(
  // requests, with the data_rdata and sfr_wdata answers
  input wire logic                   clk, rst, pc_load, pc_advance, intr_take,
  input wire logic                   data_req, data_we, data_indirect,
  input wire logic [FILE_ADDR_W-1:0] file_field,
  input wire logic [DATA_W-1:0]      status_value, data_wdata, data_rdata, sfr_wdata,
  // answers
  input wire logic [PC_W-1:0]        pc,
  input wire logic [PROG_IMPL_W-1:0] fetch_addr,
  input wire logic [SFR_IDX_W-1:0]   sfr_index,
  input wire logic                   data_valid, sfr_sel, sfr_bank, sfr_we, bank_select_bit
);
  wire dir = data_req && !data_indirect;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // own disable so the reset edge itself is judged
  a_pc_reset: assert property (disable iff (1'b0) rst |=> pc == RESET_VECTOR)
    else $error("pc not cleared by reset");
  a_intr_vec: assert property (intr_take |=> pc == INTR_VECTOR)
    else $error("interrupt entry wrong");
  a_pc_step: assert property (!intr_take && !pc_load && pc_advance |=> pc == 13'($past(pc) + 1))
    else $error("pc step wrong");
  a_fetch_wrap: assert property (fetch_addr == pc[9:0])
    else $error("fetch address not wrapped");
  a_bank_bit: assert property (!$past(rst) |-> bank_select_bit == $past(status_value[5]))
    else $error("bank bit wrong");
  a_sfr_hit: assert property (dir && file_field <= SFR_HI |=> sfr_sel && sfr_bank == $past(status_value[5]) && sfr_index == $past(file_field[4:0]))
    else $error("sfr decode wrong");
  a_sfr_write: assert property (dir && data_we && file_field <= SFR_HI |=> sfr_we && sfr_wdata == $past(data_wdata))
    else $error("sfr write strobe wrong");
  a_unimpl_zero: assert property (dir && file_field > GPR_HI |=> data_rdata == ZERO_BYTE && !sfr_we && !sfr_sel)
    else $error("unimplemented slot not empty");
  c_intr: cover property (intr_take);
  c_write: cover property (data_req && data_we);
  c_ptr: cover property (data_req && data_indirect);
endmodule
bind bmm_map bmm_sva u_sva (.clk, .rst, .pc_load, .pc_advance, .intr_take, .data_req, .data_we,
  .data_indirect, .file_field, .status_value, .data_wdata, .data_rdata, .sfr_wdata, .pc,
  .fetch_addr, .sfr_index, .data_valid, .sfr_sel, .sfr_bank, .sfr_we, .bank_select_bit);
